// File: pkg/fad_cfg.svh
// Offsets, field positions, reset values and cycle counts.
// Assumes inclusion by the decoder module only.
`ifndef FAD_CFG_SVH
`define FAD_CFG_SVH
// Register port offsets
`define FAD_REG_SEG 2'h0
`define FAD_REG_CFG 2'h1
`define FAD_REG_STAT 2'h2
// Field positions
`define FAD_SEG_BIT 0
`define FAD_CFG_DC_LSB 6
`define FAD_CFG_WIDE_BIT 5
`define FAD_STAT_QIO_BIT 6
`define FAD_STAT_QPROT_BIT 0
// Reset values
`define FAD_SEG_RST 1'h0
`define FAD_DC_RST 2'h0
`define FAD_QIO_RST 1'h0
// Dummy clocks: base plus step times dummy field
`define FAD_DUMMY_BASE 4'h4
`define FAD_DUMMY_STEP 4'h2
// Shift widths in bits, page size in bytes
`define FAD_CMD_BITS 6'h08
`define FAD_ADDR3_BITS 6'h18
`define FAD_ADDR4_BITS 6'h20
`define FAD_PAGE_BYTES 9'h100
`endif

// File: pkg/fad_pkg.sv
// Types shared by the command decoder.
// Assumes nothing beyond the cfg header.
package fad_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_READ, OP_FAST, OP_DIO, OP_DOUT, OP_QIO, OP_QOUT,
    OP_QDTR, OP_PP, OP_QPP, OP_SE, OP_BE32, OP_BE64, OP_CE,
    OP_EN4, OP_EX4, OP_EQ, OP_RQ
  } fad_op_t;
  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_RDATA, PH_WDATA, PH_TAIL, PH_SKIP
  } fad_ph_t;
  typedef struct packed {
    logic ok;
    fad_op_t op;
    logic four_b;
    logic [2:0] alanes;
    logic [2:0] dlanes;
  } fad_dec_t;
  typedef struct packed {
    logic [2:0] ck_s;
    logic [2:0] cs_s;
    logic [3:0] d1;
    logic [3:0] d2;
    fad_ph_t ph;
    fad_op_t op;
    logic four_b;
    logic [2:0] ln;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [31:0] addr;
    logic [3:0] dcnt;
    logic [7:0] osh;
    logic [3:0] ocnt;
    logic [1:0] ldw;
    logic [8:0] nbytes;
    logic wide;
    logic quad;
    logic seg;
    logic qio;
    logic [1:0] dc;
    logic [3:0] so;
    logic [3:0] oe;
    logic [7:0] rdata;
    logic ard;
    logic pv;
    logic [7:0] pb;
    logic ev;
    fad_op_t eop;
    logic [31:0] ea;
    logic [8:0] ecnt;
  } fad_st_t;
endpackage

// File: rtl/fad_decoder.sv
// Serial flash command front end: opcode decode, address forming, lane width.
// Assumes a same-clock array port answering one cycle after arr_rd_out.
//
// Overview of operation
// R1: Enter-wide command sets flag, 32-bit addresses follow
// R2: Exit-wide command clears flag, back to 24 bits
// R3: Wide mode ignores segment bit for addresses
// R4: Dedicated wide opcodes always take 32-bit address
// R5: Volatile segment register supplies upper address bits
// R6: Segment bits 7..1 read zero, bit0 resets zero
// R7: Segment bit selects upper or lower half
// R8: Continuous read crosses segments, register unchanged
// R9: Random reads stay inside selected segment
// R10: Chip erase ignores segment, takes no address
// R11: Opcode 35h enters quad protocol, enable bit kept
// R12: Opcode F5h in quad protocol returns to single line
// R13: Host waits deselect time after protocol changes
// R14: Decode the 3-byte read opcode set
// R15: Only quad io reads accepted in quad protocol
// R16: Non-normal reads insert dummy clocks from field
// R17: Program takes 1 to 256 bytes; quad program SPI only
// R18: Decode sector, half block and block erases
// R19: Dataless commands run only on byte boundary
// R20: Sample on rising clock, shift on falling
// R21: Wide flag and quad protocol clear at reset
// R22: Unknown opcode ignored, outputs released till deselect
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "fad_cfg.svh"
module fad_decoder import fad_pkg::*; #(
  parameter int ADDR_W = 25
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Serial link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_out,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Array read port
  output logic arr_rd_out,
  output logic [31:0] arr_addr_out,
  input wire logic [7:0] arr_rdata_in,
  // Program data and execution requests
  output logic prog_byte_valid_out,
  output logic [7:0] prog_byte_out,
  output logic exec_valid_out,
  output fad_op_t exec_op_out,
  output logic [31:0] exec_addr_out,
  output logic [8:0] exec_count_out,
  // Mode state
  output logic wide_flag_out,
  output logic quad_proto_out
);
  // Window mask and segment bit need at least 25 address bits
  if (ADDR_W < 25 || ADDR_W > 32) begin : gen_addr_w_check
    $error("ADDR_W out of range");
  end

  localparam logic [31:0] AMASK = 32'((64'h1 << ADDR_W) - 64'h1);

  function automatic fad_dec_t decode(input logic [7:0] b, input logic q);
    fad_dec_t d;
    d = '{ok: 1'b1, op: OP_NONE, four_b: 1'b0, alanes: 3'd1, dlanes: 3'd1};
    case (b)
      8'h03, 8'h13: d.op = q ? OP_NONE : OP_READ; // R14 R15
      8'h0B, 8'h0C: d.op = q ? OP_NONE : OP_FAST; // R14 R15
      8'hBB, 8'hBC: begin
        d.op = q ? OP_NONE : OP_DIO; // R14 R15
        d.alanes = 3'd2;
        d.dlanes = 3'd2;
      end
      8'h3B, 8'h3C: begin
        d.op = q ? OP_NONE : OP_DOUT; // R14 R15
        d.dlanes = 3'd2;
      end
      8'hEB, 8'hEC, 8'hED, 8'hEE: begin
        d.op = (b[1] ^ b[0]) ? OP_QDTR : OP_QIO; // R14 R15
        d.alanes = 3'd4;
        d.dlanes = 3'd4;
      end
      8'h6B, 8'h6C: begin
        d.op = q ? OP_NONE : OP_QOUT; // R14 R15
        d.dlanes = 3'd4;
      end
      8'h02, 8'h12: d.op = OP_PP; // R17
      8'h38, 8'h3E: begin
        d.op = q ? OP_NONE : OP_QPP; // R17
        d.alanes = 3'd4;
        d.dlanes = 3'd4;
      end
      8'h20, 8'h21: d.op = OP_SE; // R18
      8'h52, 8'h5C: d.op = OP_BE32; // R18
      8'hD8, 8'hDC: d.op = OP_BE64; // R18
      8'h60, 8'hC7: d.op = OP_CE; // R10
      8'hB7: d.op = OP_EN4;
      8'hE9: d.op = OP_EX4;
      8'h35: d.op = q ? OP_NONE : OP_EQ; // R11
      8'hF5: d.op = q ? OP_RQ : OP_NONE; // R12
      default: d.op = OP_NONE;
    endcase
    // Dedicated wide set: each opcode differs from its 3-byte twin in one nibble
    case (b)
      8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C, 8'hEE, 8'h12, 8'h3E,
      8'hDC, 8'h5C, 8'h21: d.four_b = 1'b1; // R4
      default: d.four_b = 1'b0;
    endcase
    d.ok = (d.op != OP_NONE);
    return d;
  endfunction

  function automatic logic [7:0] reg_read(input logic [1:0] a, input fad_st_t st);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `FAD_REG_SEG: r[`FAD_SEG_BIT] = st.seg; // R6
      `FAD_REG_CFG: begin
        r[`FAD_CFG_DC_LSB +: 2] = st.dc;
        r[`FAD_CFG_WIDE_BIT] = st.wide;
      end
      `FAD_REG_STAT: begin
        r[`FAD_STAT_QIO_BIT] = st.qio;
        r[`FAD_STAT_QPROT_BIT] = st.quad;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  fad_st_t s;
  fad_st_t n;
  logic rise;
  logic fall;
  logic csl;
  logic cs_rise;
  logic cs_fall;
  logic [31:0] sh_n;
  logic [5:0] cnt_n;
  logic [5:0] abits;
  logic ok_tail;
  fad_dec_t dec;

  // Edge finders look only at second and third sync stages
  assign rise = s.ck_s[1] & ~s.ck_s[2]; // R20
  assign fall = ~s.ck_s[1] & s.ck_s[2]; // R20
  assign csl = ~s.cs_s[1];
  assign cs_fall = ~s.cs_s[1] & s.cs_s[2];
  assign cs_rise = s.cs_s[1] & ~s.cs_s[2];
  assign abits = s.four_b ? `FAD_ADDR4_BITS : `FAD_ADDR3_BITS;
  assign ok_tail = (s.ph == PH_TAIL) && (s.cnt == 6'h00); // R19

  always_comb begin
    n = s;
    n.ard = 1'b0;
    n.pv = 1'b0;
    n.ev = 1'b0;
    n.rdata = 8'h00;
    n.ck_s = {s.ck_s[1:0], sclk_in};
    n.cs_s = {s.cs_s[1:0], cs_n_in};
    n.d1 = sio_in;
    n.d2 = s.d1;
    case (s.ln)
      3'd2: sh_n = {s.sh[29:0], s.d2[1:0]};
      3'd4: sh_n = {s.sh[27:0], s.d2};
      default: sh_n = {s.sh[30:0], s.d2[0]};
    endcase
    cnt_n = s.cnt + 6'(s.ln);
    dec = decode(sh_n[7:0], s.quad);
    if (reg_wr_in) begin
      case (reg_addr_in)
        `FAD_REG_SEG: n.seg = reg_wdata_in[`FAD_SEG_BIT]; // R5 R6
        `FAD_REG_CFG: n.dc = reg_wdata_in[`FAD_CFG_DC_LSB +: 2];
        `FAD_REG_STAT: n.qio = reg_wdata_in[`FAD_STAT_QIO_BIT];
        default: n.qio = s.qio;
      endcase
    end
    if (reg_rd_in) begin
      n.rdata = reg_read(reg_addr_in, s);
    end
    if (s.ldw == 2'd1) begin
      n.osh = arr_rdata_in;
    end
    if (s.ldw != 2'd0) begin
      n.ldw = s.ldw - 2'd1;
    end
    if (cs_fall) begin
      n.ph = PH_CMD;
      n.cnt = 6'h00;
      n.sh = 32'h0;
      n.ln = s.quad ? 3'd4 : 3'd1; // R11 R12
      n.nbytes = 9'h000;
      n.oe = 4'h0;
    end else if (cs_rise) begin
      if (ok_tail) begin
        case (s.op)
          OP_EN4: n.wide = 1'b1; // R1
          OP_EX4: n.wide = 1'b0; // R2
          OP_EQ: n.quad = 1'b1; // R11
          OP_RQ: n.quad = 1'b0; // R12
          default: begin
            n.ev = 1'b1;
            n.eop = s.op;
            n.ea = s.addr;
            n.ecnt = 9'h000;
          end
        endcase
      end else if (s.ph == PH_WDATA && s.cnt == 6'h00 && s.nbytes != 9'h000) begin
        n.ev = 1'b1; // R17 R19
        n.eop = s.op;
        n.ea = s.addr;
        n.ecnt = s.nbytes;
      end
      n.ph = PH_IDLE;
      n.oe = 4'h0;
      n.so = 4'h0;
    end else if (csl && rise) begin
      case (s.ph)
        PH_CMD: begin
          n.sh = sh_n;
          n.cnt = cnt_n;
          if (cnt_n == `FAD_CMD_BITS) begin
            n.cnt = 6'h00;
            n.sh = 32'h0;
            n.op = dec.op;
            n.four_b = dec.four_b | s.wide; // R1 R4
            n.ln = s.quad ? 3'd4 : dec.alanes;
            n.addr = 32'h0; // R10
            if (!dec.ok) begin
              n.ph = PH_SKIP; // R22
            end else if (dec.op == OP_CE || dec.op >= OP_EN4) begin
              n.ph = PH_TAIL;
            end else begin
              n.ph = PH_ADDR;
            end
          end
        end
        PH_ADDR: begin
          n.sh = sh_n;
          n.cnt = cnt_n;
          if (cnt_n == abits) begin
            n.cnt = 6'h00;
            // Segment bit only steers 3-byte addresses
            n.addr = s.four_b ? sh_n : {7'h00, s.seg, sh_n[23:0]}; // R3 R7 R9
            n.ln = s.quad ? 3'd4 : 3'd1;
            case (s.op)
              OP_SE, OP_BE32, OP_BE64: n.ph = PH_TAIL; // R18
              OP_PP, OP_QPP: begin
                n.ph = PH_WDATA; // R17
                n.ln = (s.quad || s.op == OP_QPP) ? 3'd4 : 3'd1;
              end
              OP_READ: begin
                n.ph = PH_RDATA; // R14
                n.ln = 3'd1;
                n.ard = 1'b1;
                n.ldw = 2'd2;
                n.ocnt = 4'h0;
              end
              default: begin
                n.ph = PH_DUMMY; // R16
                n.dcnt = `FAD_DUMMY_BASE + `FAD_DUMMY_STEP * {2'b00, s.dc};
                case (s.op)
                  OP_DIO, OP_DOUT: n.ln = 3'd2;
                  OP_QIO, OP_QOUT, OP_QDTR: n.ln = 3'd4;
                  default: n.ln = s.quad ? 3'd4 : 3'd1;
                endcase
              end
            endcase
          end
        end
        PH_DUMMY: begin
          n.dcnt = s.dcnt - 4'h1;
          if (s.dcnt == 4'h1) begin
            n.ph = PH_RDATA;
            n.ard = 1'b1;
            n.ldw = 2'd2;
            n.ocnt = 4'h0;
          end
        end
        PH_WDATA: begin
          n.sh = sh_n;
          n.cnt = cnt_n;
          if (cnt_n == `FAD_CMD_BITS) begin
            n.cnt = 6'h00;
            n.pv = 1'b1; // R17
            n.pb = sh_n[7:0];
            // Count saturates at one page
            if (s.nbytes != `FAD_PAGE_BYTES) begin
              n.nbytes = s.nbytes + 9'h001;
            end
          end
        end
        // Any clock after the last byte spoils the boundary
        PH_TAIL: n.cnt = 6'h01; // R19
        default: n.cnt = s.cnt;
      endcase
    end else if (csl && fall && s.ph == PH_RDATA && s.ldw == 2'd0) begin
      case (s.ln)
        3'd2: begin
          n.so = {2'b00, s.osh[7:6]};
          n.oe = 4'h3;
          n.osh = {s.osh[5:0], 2'b00};
        end
        3'd4: begin
          n.so = s.osh[7:4];
          n.oe = 4'hF;
          n.osh = {s.osh[3:0], 4'h0};
        end
        default: begin
          n.so = {2'b00, s.osh[7], 1'b0};
          n.oe = 4'h2;
          n.osh = {s.osh[6:0], 1'b0};
        end
      endcase
      n.ocnt = s.ocnt + 4'(s.ln);
      if (s.ocnt + 4'(s.ln) == 4'h8) begin
        n.ocnt = 4'h0;
        // Wrap inside array, segment register untouched
        n.addr = (s.addr & ~AMASK) | ((s.addr + 32'h1) & AMASK); // R8
        n.ard = 1'b1;
        n.ldw = 2'd2;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
      s.ck_s <= 3'h0;
      s.cs_s <= 3'h7;
      s.ph <= PH_IDLE;
      s.op <= OP_NONE;
      s.eop <= OP_NONE;
      s.ln <= 3'd1;
      s.wide <= 1'b0; // R21
      s.quad <= 1'b0; // R21
      s.seg <= `FAD_SEG_RST;
      s.dc <= `FAD_DC_RST;
      s.qio <= `FAD_QIO_RST;
    end else begin
      s <= n;
    end
  end

  assign sio_out = s.so;
  assign sio_oe_out = s.oe;
  assign reg_rdata_out = s.rdata;
  assign arr_rd_out = s.ard;
  assign arr_addr_out = s.addr;
  assign prog_byte_valid_out = s.pv;
  assign prog_byte_out = s.pb;
  assign exec_valid_out = s.ev;
  assign exec_op_out = s.eop;
  assign exec_addr_out = s.ea;
  assign exec_count_out = s.ecnt;
  assign wide_flag_out = s.wide;
  assign quad_proto_out = s.quad;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  wide_enter_a: assert property (cs_rise && ok_tail && s.op == OP_EN4 |=> wide_flag_out) // R1
    else $error("wide flag not set");
  wide_exit_a: assert property (cs_rise && ok_tail && s.op == OP_EX4 |=> !wide_flag_out) // R2
    else $error("wide flag not cleared");
  seg_addr_a: assert property (csl && rise && s.ph == PH_ADDR && !s.four_b // R3
    && cnt_n == abits |=> s.addr[31:24] == {7'h00, $past(s.seg)}) else $error("segment not applied");
  seg_zero_a: assert property (reg_rd_in && reg_addr_in == `FAD_REG_SEG // R6
    |=> reg_rdata_out[7:1] == 7'h00) else $error("segment upper bits not zero");
  quad_enter_a: assert property (cs_rise && ok_tail && s.op == OP_EQ // R11
    |=> quad_proto_out && $stable(s.qio)) else $error("quad entry wrong");
  quad_exit_a: assert property (cs_rise && ok_tail && s.op == OP_RQ |=> !quad_proto_out) // R12
    else $error("quad exit wrong");
  boundary_rej_a: assert property (cs_rise && s.ph == PH_TAIL && s.cnt != 6'h00 // R19
    |=> !exec_valid_out && $stable(wide_flag_out) && $stable(quad_proto_out))
    else $error("off-boundary command ran");
  chip_erase_a: assert property (exec_valid_out && exec_op_out == OP_CE // R10
    |-> exec_addr_out == 32'h0) else $error("chip erase with address");
  prog_count_a: assert property (exec_valid_out && exec_op_out inside {OP_PP, OP_QPP} // R17
    |-> exec_count_out inside {[9'h001 : 9'h100]}) else $error("program count out of range");
  skip_hiz_a: assert property (s.ph == PH_SKIP |-> sio_oe_out == 4'h0) // R22
    else $error("output driven after unknown opcode");

  read_c: cover property (s.ph == PH_RDATA && arr_rd_out);
  prog_c: cover property (exec_valid_out && exec_op_out == OP_PP);
  quad_c: cover property (cs_rise && ok_tail && s.op == OP_EQ);
endmodule

// File: dv/fad_host.sv
// Host model for the serial link: mode 0 clock, select and io lines.
// Assumes clk_in at 4 ns; a half sclk period is 6 clocks, 48 ns per sclk.
`timescale 1ns/1ns
module fad_host (
  // Clock
  input wire logic clk_in,
  // Link
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] sio_drv_out,
  input wire logic [3:0] sio_rx_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sio_drv_out = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start();
    cs_n_out <= 1'b0;
    wt(6);
  endtask
  // Last shift ends on a falling edge, so select rises on a byte boundary
  task automatic stop();
    wt(6);
    cs_n_out <= 1'b1;
    wt(10);
  endtask
  // Clock stands low between frames
  task automatic xfer(input logic [31:0] v, input int n, input int ln,
                      output logic [31:0] r);
    logic [3:0] m;
    m = (4'h1 << ln) - 4'h1;
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sio_drv_out <= 4'(v >> (i * ln)) & m;
      wt(6);
      sclk_out <= 1'b1;
      r = (r << ln) | (ln == 1 ? 32'(sio_rx_in[1]) : 32'(sio_rx_in & m));
      wt(6);
      sclk_out <= 1'b0;
    end
  endtask
endmodule

// File: dv/fad_decoder_tb_top.sv
// Bench for the command decoder: host model, array model, register tasks.
// Assumes ADDR_W of 25, so stream addresses wrap within 25 bits.
`timescale 1ns/1ns
module fad_decoder_tb_top;
  import fad_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic sclk, cs_n, reg_wr = 1'b0, reg_rd = 1'b0, arr_rd, prog_v, exec_v, wide, quad;
  logic [3:0] hdrv, sio_out, sio_oe_out, sio_w;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, arr_rdata = 8'h00, prog_byte;
  logic [31:0] arr_addr, exec_addr, r, seed = 32'h3BD03424;
  logic [8:0] exec_cnt;
  fad_op_t exec_op;
  int mismatches = 0, total_checks = 0, cyc = 0, oe_n = 0, ex_n = 0;
  logic [31:0] aq[$];
  logic [7:0] pq[$];
  logic m_seg = 1'b0, m_wide = 1'b0, m_quad = 1'b0;
  logic [1:0] m_dc = 2'h0;
  logic [7:0] ops [7] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'hED};
  int al [7] = '{1, 1, 2, 1, 4, 1, 4};
  int dl [7] = '{1, 1, 2, 2, 4, 4, 4};
  always #2 clk_in = ~clk_in;
  // Wire level: device where enabled, host elsewhere
  assign sio_w = (sio_oe_out & sio_out) | (~sio_oe_out & hdrv);
  fad_host u_fad_host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
    .sio_drv_out(hdrv), .sio_rx_in(sio_w));
  fad_decoder #(.ADDR_W(25)) u_fad_decoder (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .sio_in(sio_w), .sio_out(sio_out),
    .sio_oe_out(sio_oe_out), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .arr_rd_out(arr_rd), .arr_addr_out(arr_addr), .arr_rdata_in(arr_rdata),
    .prog_byte_valid_out(prog_v), .prog_byte_out(prog_byte), .exec_valid_out(exec_v),
    .exec_op_out(exec_op), .exec_addr_out(exec_addr), .exec_count_out(exec_cnt),
    .wide_flag_out(wide), .quad_proto_out(quad));
  function automatic logic [7:0] mem(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5C;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Array answers one cycle after the request; noise otherwise
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    arr_rdata <= arr_rd ? mem(arr_addr) : ~arr_rdata;
    if (arr_rd) aq.push_back(arr_addr);
    if (prog_v) pq.push_back(prog_byte);
    if (|sio_oe_out) oe_n <= oe_n + 1;
    if (exec_v) ex_n <= ex_n + 1;
    if (cyc == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e, input string n);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    // Data launched at the previous edge still stands here
    @(posedge clk_in);
    chk(n, e, 32'(reg_rdata));
  endtask
  task automatic sh(input logic [31:0] v, input int n, input int ln);
    u_fad_host.xfer(v, n, ln, r);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_fad_host.start();
    sh(op, m_quad ? 2 : 8, m_quad ? 4 : 1);
  endtask
  task automatic mode(input logic [7:0] op, input int x);
    cmd(op);
    sh(0, x, 1);
    u_fad_host.stop();
  endtask
  task automatic rdf(input logic [7:0] op, input int a_l, input int d_l,
                     input logic [31:0] a, input bit ok);
    int dm, o0;
    logic [31:0] ea;
    bit w;
    w = m_wide || (op inside {8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C, 8'hEE});
    ea = (w ? a : {7'h0, m_seg, a[23:0]}) & 32'h1FFFFFF;
    dm = (op == 8'h03 || op == 8'h13) ? 0 : 4 + 2 * m_dc;
    if (m_quad) begin
      a_l = 4;
      d_l = 4;
    end
    aq.delete();
    o0 = oe_n;
    cmd(op);
    sh(a, (w ? 32 : 24) / a_l, a_l);
    sh(rnd(), dm, d_l);
    sh(rnd(), 16 / d_l, d_l);
    u_fad_host.stop();
    if (ok) begin
      chk("rd_addr", ea, aq[0]);
      chk("rd_next", (ea + 1) & 32'h1FFFFFF, aq[1]);
      chk("rd_data", {mem(ea), mem((ea + 1) & 32'h1FFFFFF)}, r[15:0]);
    end else begin
      chk("rej_fetch", 0, aq.size());
      chk("rej_oe", o0, oe_n);
    end
  endtask
  task automatic er(input logic [7:0] op, input fad_op_t eo, input int ab,
                    input logic [31:0] a, input int x);
    int e0;
    e0 = ex_n;
    cmd(op);
    sh(a, ab / (m_quad ? 4 : 1), m_quad ? 4 : 1);
    sh(0, x, 1);
    u_fad_host.stop();
    chk("ex_cnt", x ? e0 : e0 + 1, ex_n);
    if (x == 0) chk("ex_op", eo, exec_op);
    if (x == 0 && ab > 0) chk("ex_addr", ab == 32 ? a : {7'h0, m_seg, a[23:0]}, exec_addr);
  endtask
  task automatic pp(input logic [7:0] op, input fad_op_t eo, input int d_l,
                    input int nb, input logic [31:0] a);
    logic [7:0] b[$];
    int e0;
    e0 = ex_n;
    pq.delete();
    cmd(op);
    // Quad program takes its address on four lines as well
    sh(a, 24 / d_l, d_l);
    for (int i = 0; i < nb; i++) begin
      b.push_back(8'(rnd()));
      sh(b[i], 8 / d_l, d_l);
    end
    u_fad_host.stop();
    chk("pp_cnt", e0 + 1, ex_n);
    chk("pp_op", eo, exec_op);
    chk("pp_n", nb, exec_cnt);
    chk("pp_addr", {7'h0, m_seg, a[23:0]}, exec_addr);
    for (int i = 0; i < nb; i++) chk("pp_byte", b[i], pq[i]);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(2'h0, 0, "seg_rst");
    rd(2'h1, 0, "cfg_rst");
    rd(2'h2, 0, "stat_rst");
    wr(2'h0, 8'hFF);
    rd(2'h0, 1, "seg_ro");
    rd(2'h3, 0, "unmapped");
    $display("test registers done");
    // First pass starts at the top byte of a segment to cross it
    for (int i = 0; i < 14; i++) begin
      m_seg = 1'(rnd());
      m_dc = 2'(rnd());
      wr(2'h0, {7'h0, m_seg});
      wr(2'h1, {m_dc, 6'h00});
      rdf(ops[i % 7], al[i % 7], dl[i % 7], i ? rnd() : 32'hFFFFFF, 1);
      rd(2'h0, m_seg, "seg_keep");
    end
    $display("test reads done");
    mode(8'hB7, 1);
    chk("wide_rej", 0, wide);
    mode(8'hB7, 0);
    m_wide = 1'b1;
    chk("wide_on", 1, wide);
    rd(2'h1, {m_dc, 6'h20}, "cfg_wide");
    rdf(8'h03, 1, 1, {7'h0, ~m_seg, 24'(rnd())}, 1);
    mode(8'hE9, 0);
    m_wide = 1'b0;
    chk("wide_off", 0, wide);
    rdf(8'h0B, 1, 1, rnd(), 1);
    rdf(8'h13, 1, 1, {7'h0, ~m_seg, 24'(rnd())}, 1);
    $display("test wide done");
    m_seg = 1'b1;
    wr(2'h0, 8'h01);
    er(8'h20, OP_SE, 24, rnd(), 0);
    er(8'h52, OP_BE32, 24, rnd(), 0);
    er(8'hD8, OP_BE64, 24, rnd(), 0);
    er(8'h60, OP_CE, 0, 0, 0);
    er(8'hC7, OP_CE, 0, 0, 0);
    er(8'hD8, OP_BE64, 24, rnd(), 1);
    er(8'h21, OP_SE, 32, rnd(), 0);
    pp(8'h02, OP_PP, 1, 3, rnd());
    pp(8'h38, OP_QPP, 4, 256, rnd());
    $display("test erase program done");
    wr(2'h2, 8'h40);
    mode(8'h35, 0);
    m_quad = 1'b1;
    chk("quad_on", 1, quad);
    rd(2'h2, 8'h41, "stat_quad");
    rdf(8'h03, 1, 1, rnd(), 0);
    rdf(8'hEB, 4, 4, rnd(), 1);
    er(8'h20, OP_SE, 24, rnd(), 0);
    mode(8'hF5, 0);
    m_quad = 1'b0;
    chk("quad_off", 0, quad);
    rd(2'h2, 8'h40, "stat_spi");
    rdf(8'hFF, 1, 1, rnd(), 0);
    $display("test quad done");
    mode(8'hB7, 0);
    mode(8'h35, 0);
    chk("pre_rst", 3, {wide, quad});
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("wide_rst", 0, wide);
    chk("quad_rst", 0, quad);
    rd(2'h0, 0, "seg_rst2");
    $display("test reset done");
    tally_and_finish();
  end
endmodule
